// ==== core/acf_defines.svh ====
// Register offsets, field positions, reset values and build limits
// of the channel buffer. Assumes inclusion by the package, checker and testbench.
`ifndef ACF_DEFINES_SVH
`define ACF_DEFINES_SVH

// ===
// Register byte offsets (one aligned word each)
`define ACF_OFF_CTRL      8'h00
`define ACF_OFF_STATUS    8'h04
`define ACF_OFF_INT_STAT  8'h08
`define ACF_OFF_INT_EN    8'h0c
`define ACF_OFF_INT_CLR   8'h10

// ===
// Control register fields
`define ACF_CTRL_RDY_LSB  0
`define ACF_CTRL_VLD_LSB  2
`define ACF_CTRL_INJ_BIT  4
`define ACF_CTRL_RESET    5'h00

// ===
// Interrupt bit positions (status, enable, clear share them)
`define ACF_INT_OVF       0
`define ACF_INT_UNF       1
`define ACF_INT_ERR       2
`define ACF_INT_W         3
`define ACF_INT_RESET     3'h0

// ===
// Status register fields above the occupancy count
`define ACF_STAT_FULL     24
`define ACF_STAT_EMPTY    25

// ===
// Build limits on the depth
`define ACF_DEPTH_MIN     16
`define ACF_DEPTH_MAX     131072

`endif

// ==== core/acf_pkg.sv ====
// Types shared by the channel buffer core.
// Assumes the defines header sits in the same folder.
package acf_pkg;
    `include "acf_defines.svh"

    // ===
    // Build form of the block
    typedef enum logic [1:0]
    {
        ACF_FORM_FIFO  = 2'b00,   // Full buffer
        ACF_FORM_SLICE = 2'b01,   // Two-word register slice
        ACF_FORM_PASS  = 2'b10    // Wires only
    } acf_form_t;

    // ===
    // Application type of the buffer
    typedef enum logic [1:0]
    {
        ACF_APP_DATA   = 2'b00,   // Plain data
        ACF_APP_PACKET = 2'b01,   // Hold words until a packet ends
        ACF_APP_LOWLAT = 2'b10    // Low-latency data
    } acf_app_t;

    // ===
    // Level condition used for ready (full side) and valid
    typedef enum logic [1:0]
    {
        ACF_LVL_EDGE   = 2'b00,   // Full or empty
        ACF_LVL_ALMOST = 2'b01,   // One word from the edge
        ACF_LVL_PROG   = 2'b10    // Programmable threshold
    } acf_lvl_t;
endpackage : acf_pkg

// ==== core/acf_fifo.sv ====
// Channel buffer core: first-word fall-through store between an
// upstream stream master and a downstream slave, with AHB-Lite
// registers and one level interrupt. Assumes both stream partners
// and the bus master run on sys_clk.
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module acf_fifo #(
    parameter int                DW         = 32,   // Channel width
    parameter int                DEPTH      = 1024, // Words
    parameter acf_pkg::acf_form_t FORM      = acf_pkg::ACF_FORM_FIFO,
    parameter acf_pkg::acf_app_t APP        = acf_pkg::ACF_APP_DATA,
    parameter bit                ECC_EN     = 1'b1, // Check bit
    parameter bit                FLAGS_EN   = 1'b1, // Ovf/unf out
    parameter bit                DUAL_COUNT = 1'b0, // Two counts
    parameter int                PFULL      = 1020, // Full level
    parameter int                PEMPTY     = 4     // Empty level
) (
    input  wire logic          sys_clk,      // System clock
    input  wire logic          resetn,       // Async reset, low
    input  wire logic          hsel,         // Slave select
    input  wire logic [31:0]   haddr,        // Byte address
    input  wire logic [1:0]    htrans,       // Transfer type
    input  wire logic          hwrite,       // Write when high
    input  wire logic [2:0]    hsize,        // Transfer size
    input  wire logic [31:0]   hwdata,       // Write data
    input  wire logic          hready,       // Bus ready in
    output logic               hreadyout,    // Slave ready
    output logic [31:0]        hrdata,       // Read data
    output logic               hresp,        // Always OKAY
    input  wire logic          sValid,       // Upstream valid
    output logic               sReady,       // Upstream ready
    input  wire logic [DW-1:0] sData,        // Upstream word
    input  wire logic          sLast,        // Upstream packet end
    output logic               mValid,       // Downstream valid
    input  wire logic          mReady,       // Downstream ready
    output logic [DW-1:0]      mData,        // Downstream word
    output logic               mLast,        // Downstream end
    output logic [$clog2(DEPTH):0] dataCount,   // Words held
    output logic [$clog2(DEPTH):0] wrDataCount, // Write-side count
    output logic [$clog2(DEPTH):0] rdDataCount, // Read-side count
    output logic               overflow,     // Write refused
    output logic               underflow,    // Read refused
    output logic               irq           // Level interrupt
);
    import acf_pkg::*;

    // ===
    // Build constants and checks
    localparam int AW  = $clog2(DEPTH);
    localparam int EAW = (FORM == ACF_FORM_SLICE) ? 1 : AW;
    localparam int WW  = DW + 2;            // Data, last, check
    localparam logic [AW:0] CAP = (AW+1)'(1 << EAW);
    localparam logic [AW:0] PF  = (AW+1)'(PFULL);
    localparam logic [AW:0] PE  = (AW+1)'(PEMPTY);

    // Refuse depths and thresholds the logic cannot serve
    generate
        if (DEPTH < `ACF_DEPTH_MIN || DEPTH > `ACF_DEPTH_MAX ||
            (DEPTH & (DEPTH - 1)) != 0)
        begin : gBadDepth
            $error("depth must be a power of two in range");
        end
        if (PFULL < 1 || PFULL > DEPTH || PEMPTY < 0 ||
            PEMPTY >= DEPTH || DW < 1)
        begin : gBadLevel
            $error("threshold or width out of range");
        end
    endgenerate

    // ===
    // Level decode shared by the ready and valid sides
    function automatic logic atLevel
    (
        input logic [AW:0] cnt,   // Occupancy
        input logic [1:0]  mode,  // Selected condition
        input logic        full   // Full side when high
    );
        logic hit;
        hit = 1'b0;
        if (full)
        begin
            case (mode)
                ACF_LVL_EDGE:   hit = (cnt >= CAP);
                ACF_LVL_ALMOST: hit = (cnt >= CAP - 1'b1);
                ACF_LVL_PROG:   hit = (cnt >= PF);
                default:        hit = (cnt >= CAP);
            endcase
        end
        else
        begin
            case (mode)
                ACF_LVL_EDGE:   hit = (cnt == '0);
                ACF_LVL_ALMOST: hit = (cnt <= 1);
                ACF_LVL_PROG:   hit = (cnt <= PE);
                default:        hit = (cnt == '0);
            endcase
        end
        return hit;
    endfunction : atLevel

    // ===
    // Register state
    logic [4:0]  ctrl_r;        // Modes and injection
    logic [2:0]  intStat_r;     // Sticky events
    logic [2:0]  intEn_r;       // Interrupt enables
    logic [7:0]  addr_r;        // Latched write offset
    logic        wrPend_r;      // Write data phase pending
    logic [31:0] rdData_r;      // Read data for data phase
    logic [31:0] statusWord;    // Live status image
    logic [2:0]  clrBits;       // Clear strobes this cycle
    logic [2:0]  events;        // Event pulses this cycle
    logic        addrPhase;     // Valid address phase

    // Stream side handshakes
    logic        wrEn;          // Word accepted
    logic        rdEn;          // Word delivered
    logic        isFull;        // Store full
    logic        isEmpty;       // Store empty
    logic        ovfEvt;        // Write refused
    logic        unfEvt;        // Read refused
    logic        errEvt;        // Check bit mismatch
    logic [AW:0] count_r;       // Occupancy

    // ===
    // Storage forms
    generate
        if (FORM == ACF_FORM_PASS)
        begin : gPass
            // Wires only, nothing held
            assign sReady  = mReady;
            assign mValid  = sValid;
            assign mData   = sData;
            assign mLast   = sLast;
            assign wrEn    = sValid & mReady;
            assign rdEn    = wrEn;
            assign isFull  = 1'b0;
            assign isEmpty = 1'b1;
            assign ovfEvt  = 1'b0;
            assign unfEvt  = 1'b0;
            assign errEvt  = 1'b0;
            assign count_r = '0;
        end
        else
        begin : gStore
            logic [WW-1:0]  mem [0:(1<<EAW)-1]; // Word store
            logic [EAW-1:0] wrPtr_r;            // Next write slot
            logic [EAW-1:0] rdPtr_r;            // Oldest word slot
            logic [EAW-1:0] rdPtrNxt;           // Slot after a read
            logic [WW-1:0]  head_r;             // Word at the output
            logic [WW-1:0]  wrWord;             // Word to store
            logic [AW:0]    cnt;                // Occupancy
            logic [AW:0]    pkts_r;             // Whole packets held
            logic           pktOk;              // Packet gate
            logic           vldRaw;             // Valid before gate

            assign cnt     = count_r;
            assign isFull  = (cnt == CAP);
            assign isEmpty = (cnt == '0);
            // Ready drops on the selected full-side condition
            assign sReady  = ~atLevel(cnt, ctrl_r[`ACF_CTRL_RDY_LSB +: 2],
                                      1'b1);
            assign vldRaw  = ~atLevel(cnt, ctrl_r[`ACF_CTRL_VLD_LSB +: 2],
                                      1'b0) & ~isEmpty;
            // Packet type waits for a packet end to be stored
            assign pktOk   = (APP != ACF_APP_PACKET) ||
                             (pkts_r != '0);
            assign mValid  = vldRaw & pktOk;
            assign wrEn    = sValid & sReady & ~isFull;
            assign rdEn    = mValid & mReady;
            assign ovfEvt  = sValid & isFull;
            assign unfEvt  = mReady & isEmpty;
            assign rdPtrNxt = rdPtr_r + EAW'(rdEn);
            assign mData   = head_r[DW-1:0];
            assign mLast   = head_r[DW];
            // Check bit is even parity, inverted on injection
            assign wrWord  = {ECC_EN & ((^{sLast, sData}) ^
                              ctrl_r[`ACF_CTRL_INJ_BIT]),
                              sLast, sData};
            assign errEvt  = ECC_EN & rdEn &
                             ((^head_r[DW:0]) != head_r[DW+1]);

            // Store accepted words; refused ones never land
            always_ff @(posedge sys_clk)
            begin
                if (wrEn)
                begin
                    mem[wrPtr_r] <= wrWord;
                end
            end

            // Head word follows the read pointer, bypassing a
            // write into the very slot it is about to show
            always_ff @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    head_r <= '0;
                end
                else if (wrEn && wrPtr_r == rdPtrNxt)
                begin
                    head_r <= wrWord;
                end
                else
                begin
                    head_r <= mem[rdPtrNxt];
                end
            end

            // Pointers move only on accepted transfers
            always_ff @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    wrPtr_r <= '0;
                    rdPtr_r <= '0;
                end
                else
                begin
                    wrPtr_r <= wrPtr_r + EAW'(wrEn);
                    rdPtr_r <= rdPtrNxt;
                end
            end

            // Occupancy count
            always_ff @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    count_r <= '0;
                end
                else
                begin
                    count_r <= count_r + (AW+1)'(wrEn)
                                       - (AW+1)'(rdEn);
                end
            end

            // Whole-packet count for the packet type
            always_ff @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    pkts_r <= '0;
                end
                else
                begin
                    pkts_r <= pkts_r + (AW+1)'(wrEn & sLast)
                                     - (AW+1)'(rdEn & mLast);
                end
            end
        end
    endgenerate

    // ===
    // Occupancy outputs
    // Common clock shows one count; the split build mirrors it on
    // a write-side count and a read-side count one cycle behind
    assign dataCount   = count_r;
    assign wrDataCount = DUAL_COUNT ? count_r : '0;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdDataCount <= '0;
        end
        else
        begin
            rdDataCount <= DUAL_COUNT ? count_r : '0;
        end
    end

    // Overflow and underflow pulses, registered
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            overflow  <= 1'b0;
            underflow <= 1'b0;
        end
        else
        begin
            overflow  <= FLAGS_EN & ovfEvt;
            underflow <= FLAGS_EN & unfEvt;
        end
    end

    // ===
    // AHB-Lite slave: zero wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdData_r;
    assign addrPhase = hsel & htrans[1] & hready;

    // Status image: flags above the count
    always_comb
    begin
        statusWord = '0;
        statusWord[AW:0] = count_r;
        statusWord[`ACF_STAT_FULL]  = isFull;
        statusWord[`ACF_STAT_EMPTY] = isEmpty;
    end

    // Latch a word write for its data phase
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wrPend_r <= 1'b0;
            addr_r   <= '0;
        end
        else
        begin
            wrPend_r <= addrPhase & hwrite & (hsize == 3'h2);
            addr_r   <= haddr[7:0];
        end
    end

    // Read data captured at the address phase
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdData_r <= '0;
        end
        else if (addrPhase && !hwrite)
        begin
            case (haddr[7:0])
                `ACF_OFF_CTRL:     rdData_r <= {27'h0, ctrl_r};
                `ACF_OFF_STATUS:   rdData_r <= statusWord;
                `ACF_OFF_INT_STAT: rdData_r <= {29'h0, intStat_r};
                `ACF_OFF_INT_EN:   rdData_r <= {29'h0, intEn_r};
                default:           rdData_r <= 32'h0; // Unmapped
            endcase
        end
    end

    // Control and enable registers
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_r  <= `ACF_CTRL_RESET;
            intEn_r <= `ACF_INT_RESET;
        end
        else if (wrPend_r)
        begin
            if (addr_r == `ACF_OFF_CTRL)
            begin
                ctrl_r <= hwdata[4:0];
            end
            if (addr_r == `ACF_OFF_INT_EN)
            begin
                intEn_r <= hwdata[2:0];
            end
        end
    end

    // ===
    // Interrupts: sticky events, a new event wins over its clear
    assign clrBits = (wrPend_r && addr_r == `ACF_OFF_INT_CLR) ?
                     hwdata[2:0] : 3'h0;
    assign events  = {errEvt, unfEvt, ovfEvt};

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            intStat_r <= `ACF_INT_RESET;
        end
        else
        begin
            intStat_r <= (intStat_r & ~clrBits) | events;
        end
    end

    assign irq = |(intStat_r & intEn_r);
endmodule : acf_fifo

// ==== dv/acf_fifo_properties.sv ====
// Checker of the channel buffer ports: flow, levels and event pulses.
// Assumes one clock domain and the bind below on every core instance.
`timescale 1ns/1ps
`include "acf_defines.svh"
module acf_fifo_properties
#(
    parameter int DW     = 32,  // Word width
    parameter int DEPTH  = 16,  // Words
    parameter int PFULL  = 12,  // Full level
    parameter int PEMPTY = 4,   // Empty level
    parameter int CW     = $clog2(DEPTH) + 1 // Count width
) (
    input wire logic          sys_clk,   // Clock
    input wire logic          resetn,    // Reset, low
    input wire logic          hsel,      // Bus select
    input wire logic [31:0]   haddr,     // Bus address
    input wire logic [1:0]    htrans,    // Bus type
    input wire logic          hwrite,    // Bus write
    input wire logic [2:0]    hsize,     // Bus size
    input wire logic [31:0]   hwdata,    // Bus data
    input wire logic          hready,    // Bus ready
    input wire logic          sValid,    // Upstream valid
    input wire logic          sReady,    // Upstream ready
    input wire logic          mValid,    // Downstream valid
    input wire logic          mReady,    // Downstream ready
    input wire logic [DW-1:0] mData,     // Head word
    input wire logic [CW-1:0] dataCount, // Words held
    input wire logic          overflow,  // Write refused
    input wire logic          underflow  // Read refused
);
    logic       wrPend_r;  // Write data phase due
    logic [7:0] wrAddr_r;  // Its address
    logic [3:0] mode_r;    // Tracked level modes
    logic       expReady;  // Ready the mode implies
    logic       expValid;  // Valid the mode implies

    // ===
    // Helper: follow control writes to know the selected modes
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
            mode_r   <= 4'h0;
        end
        else if (hready)
        begin
            wrPend_r <= hsel && htrans[1] && hwrite && hsize == 3'h2;
            wrAddr_r <= haddr[7:0];
            if (wrPend_r && wrAddr_r == `ACF_OFF_CTRL)
                mode_r <= hwdata[3:0];
        end
    end
    // Levels at which ready and valid must drop
    always_comb
    begin
        case (mode_r[1:0])
            2'h1:    expReady = dataCount < DEPTH - 1;
            2'h2:    expReady = dataCount < PFULL;
            default: expReady = dataCount < DEPTH;
        endcase
        case (mode_r[3:2])
            2'h1:    expValid = dataCount > 1;
            2'h2:    expValid = dataCount > PEMPTY;
            default: expValid = dataCount > 0;
        endcase
    end

    // ===
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    chk_count_track: assert property (
        dataCount == $past(dataCount) + $past(sValid && sReady)
        - $past(mValid && mReady))
        else $error("count does not follow the transfers");
    chk_full_block: assert property (
        dataCount == DEPTH |-> !sReady)
        else $error("ready while full");
    chk_empty_quiet: assert property (
        dataCount == 0 |-> !mValid)
        else $error("valid while empty");
    chk_ready_mode: assert property (
        sReady == expReady)
        else $error("ready does not match the selected level");
    chk_valid_mode: assert property (
        mValid == expValid)
        else $error("valid does not match the selected level");
    chk_ovf_pulse: assert property (
        overflow == $past(sValid && dataCount == DEPTH))
        else $error("overflow pulse wrong");
    chk_unf_pulse: assert property (
        mReady && dataCount == 0 |=> underflow)
        else $error("underflow pulse missing");
    chk_head_hold: assert property (
        mValid && !mReady |=> mValid && $stable(mData))
        else $error("head word changed before taken");
endmodule : acf_fifo_properties

bind acf_fifo acf_fifo_properties #(.DW(DW), .DEPTH(DEPTH),
    .PFULL(PFULL), .PEMPTY(PEMPTY)) u_acf_fifo_properties (
    .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .sValid(sValid), .sReady(sReady),
    .mValid(mValid), .mReady(mReady), .mData(mData),
    .dataCount(dataCount), .overflow(overflow), .underflow(underflow));

// ==== dv/acf_stream_partner.sv ====
// Stream partner: upstream source of counting words, downstream sink
// that counts words and order faults. Assumes the core's clock.
`timescale 1ns/1ps
module acf_stream_partner
#(
    parameter int DW = 32  // Word width
) (
    input  wire logic          sys_clk, // Clock
    input  wire logic          resetn,  // Reset, low
    input  wire logic          sendEn,  // Offer words
    input  wire logic          takeEn,  // Accept words
    output logic               sValid,  // Upstream valid
    input  wire logic          sReady,  // Upstream ready
    output logic [DW-1:0]      sData,   // Upstream word
    output logic               sLast,   // Packet end
    input  wire logic          mValid,  // Downstream valid
    output logic               mReady,  // Downstream ready
    input  wire logic [DW-1:0] mData,   // Downstream word
    input  wire logic          mLast,   // Downstream end
    output logic [15:0]        rxCount, // Words taken
    output logic [15:0]        rxBad    // Words out of order
);
    logic [DW-1:0] txWord_r; // Word on offer

    // Source: an offered word stays until the handshake
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sValid   <= 1'b0;
            txWord_r <= '0;
        end
        else if (!sValid || sReady)
        begin
            if (sValid)
                txWord_r <= txWord_r + 1'b1; // Next word
            sValid <= sendEn;
        end
    end
    // Idle lines show the inverse
    assign sData  = sValid ? txWord_r : ~txWord_r;
    assign sLast  = sValid ? txWord_r[0] : ~txWord_r[0];
    assign mReady = takeEn;

    // Sink: take only on valid and ready, words must count up
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rxCount <= 16'h0000;
            rxBad   <= 16'h0000;
        end
        else if (mValid && mReady)
        begin
            rxCount <= rxCount + 16'h0001;
            if (mData !== DW'(rxCount) || mLast !== rxCount[0])
                rxBad <= rxBad + 16'h0001; // Out of order
        end
    end
endmodule : acf_stream_partner

// ==== dv/test_acf_fifo.sv ====
// Testbench of the channel buffer: bus tasks, level sweep, events.
// Assumes the core, its package, checker and partner are compiled.
`timescale 1ns/1ps
`include "acf_defines.svh"
`define CHECK_EQ(what, exp, got) \
    begin \
        checksDone++; \
        if ((got) !== (exp)) \
        begin \
            numErrors++; \
            $display("unexpected %s exp %h got %h", what, exp, got); \
        end \
    end
module test_acf_fifo;
    import acf_pkg::*;
    localparam int DEPTH  = 16;  // Small depth for short fills
    localparam int PFULL  = 12;  // Full threshold
    localparam int PEMPTY = 4;   // Empty threshold
    localparam int CW     = $clog2(DEPTH) + 1; // Count width
    logic          sys_clk = 1'b0;
    logic          resetn, hsel, hwrite, hready, hreadyout, irq, hresp;
    logic          mLast;
    logic [31:0]   haddr, hwdata, hrdata, rd;
    logic [1:0]    htrans;
    logic [2:0]    hsize;
    logic          sValid, sReady, sLast, mValid, mReady;
    logic [31:0]   sData, mData;
    logic [CW-1:0] dataCount, wrDataCount, rdDataCount;
    logic          overflow, underflow, sendEn, takeEn;
    logic [15:0]   rxCount, rxBad;
    int            numErrors = 0;  // Mismatches
    int            checksDone = 0; // Comparisons
    int            cycles = 0;     // Run length
    logic [7:0]    regAddr[5] = '{`ACF_OFF_CTRL, `ACF_OFF_STATUS,
                                  `ACF_OFF_INT_STAT, `ACF_OFF_INT_EN, 8'h20};
    logic [31:0]   regInit[5] = '{32'h0, 32'h1 << `ACF_STAT_EMPTY,
                                  32'h0, 32'h0, 32'h0};
    logic [CW-1:0] fullLvl[3] = '{CW'(DEPTH), CW'(DEPTH-1), CW'(PFULL)};
    logic [CW-1:0] emptyLvl[3] = '{CW'(0), CW'(1), CW'(PEMPTY)};

    always #25 sys_clk = ~sys_clk;
    assign hready = hreadyout;

    acf_fifo #(.DW(32), .DEPTH(DEPTH), .PFULL(PFULL), .PEMPTY(PEMPTY))
    u_acf_fifo (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .sValid(sValid), .sReady(sReady),
        .sData(sData), .sLast(sLast), .mValid(mValid), .mReady(mReady),
        .mData(mData), .mLast(mLast), .dataCount(dataCount),
        .wrDataCount(wrDataCount), .rdDataCount(rdDataCount),
        .overflow(overflow),
        .underflow(underflow), .irq(irq));
    acf_stream_partner #(.DW(32)) u_acf_stream_partner (
        .sys_clk(sys_clk), .resetn(resetn), .sendEn(sendEn),
        .takeEn(takeEn), .sValid(sValid), .sReady(sReady), .sData(sData),
        .sLast(sLast), .mValid(mValid), .mReady(mReady), .mData(mData),
        .mLast(mLast), .rxCount(rxCount), .rxBad(rxBad));

    // ===
    // Bus tasks
    task automatic busCycle(input logic [7:0] a, input logic wr,
                            input logic [31:0] wd, output logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge sys_clk); while (hready !== 1'b1);
        d = hrdata;
    endtask : busCycle
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        busCycle(a, 1'b1, d, unused);
    endtask : regWrite
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    task automatic finish_test;
        $display("checks %0d errors %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    // Hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            numErrors++;
            finish_test();
        end
    end

    // ===
    // Main sequence
    initial
    begin
        {resetn, hsel, hwrite, htrans, sendEn, takeEn} <= '0;
        haddr  <= 32'h0;
        hwdata <= 32'h0;
        hsize  <= 3'h2;
        tick(4);
        resetn <= 1'b1;
        tick(1);
        `CHECK_EQ("count", CW'(0), dataCount)
        `CHECK_EQ("valid", 1'b0, mValid)
        `CHECK_EQ("write count", CW'(0), wrDataCount)
        `CHECK_EQ("read count", CW'(0), rdDataCount)
        `CHECK_EQ("response", 1'b0, hresp)
        for (int i = 0; i < 5; i++)
        begin
            busCycle(regAddr[i], 1'b0, 32'h0, rd);
            `CHECK_EQ("register", regInit[i], rd)
        end
        // Fill and drain once per level mode
        for (int i = 0; i < 3; i++)
        begin
            regWrite(`ACF_OFF_CTRL, 32'(i * 5));
            sendEn <= 1'b1;
            tick(40);
            `CHECK_EQ("fill level", fullLvl[i], dataCount)
            if (i == 0)
            begin
                busCycle(`ACF_OFF_STATUS, 1'b0, 32'h0, rd);
                `CHECK_EQ("status", 32'h100_0000 | DEPTH, rd)
            end
            sendEn <= 1'b0;
            takeEn <= 1'b1;
            tick(40);
            `CHECK_EQ("drain level", emptyLvl[i], dataCount)
            takeEn <= 1'b0;
            if (i == 0)
            begin
                // Events, mask, enable, clear
                busCycle(`ACF_OFF_INT_STAT, 1'b0, 32'h0, rd);
                `CHECK_EQ("events", 32'h3, rd)
                `CHECK_EQ("irq masked", 1'b0, irq)
                regWrite(`ACF_OFF_INT_EN, 32'h2);
                tick(1);
                `CHECK_EQ("irq raised", 1'b1, irq)
                regWrite(`ACF_OFF_INT_CLR, 32'h3);
                tick(1);
                `CHECK_EQ("irq cleared", 1'b0, irq)
                busCycle(`ACF_OFF_INT_STAT, 1'b0, 32'h0, rd);
                `CHECK_EQ("events cleared", 32'h0, rd)
            end
        end
        busCycle(`ACF_OFF_CTRL, 1'b0, 32'h0, rd);
        `CHECK_EQ("control", 32'ha, rd)
        `CHECK_EQ("words taken", 16'd41, rxCount)
        `CHECK_EQ("order faults", 16'd0, rxBad)
        // Injected check error
        regWrite(`ACF_OFF_CTRL, 32'h1 << `ACF_CTRL_INJ_BIT);
        sendEn <= 1'b1;
        takeEn <= 1'b1;
        tick(4);
        sendEn <= 1'b0;
        tick(10);
        takeEn <= 1'b0;
        busCycle(`ACF_OFF_INT_STAT, 1'b0, 32'h0, rd);
        `CHECK_EQ("check error", 1'b1, rd[`ACF_INT_ERR])
        finish_test();
    end
endmodule : test_acf_fifo
